// *** hw/pmt_pkg.sv ***
// pmt_pkg: register map, field layout, reset values and codes of the period match timer
package pmt_pkg;

  // ==========================================================================
  // register byte addresses on the apb bus
  // ==========================================================================
  localparam logic [7:0] PMT_OFF_CTRL   = 8'h00;  // timer_control_register
  localparam logic [7:0] PMT_OFF_COUNT  = 8'h04;  // count_register
  localparam logic [7:0] PMT_OFF_PERIOD = 8'h08;  // period_register
  localparam logic [7:0] PMT_OFF_STATUS = 8'h0C;  // peripheral_irq_flags, read clears
  localparam logic [7:0] PMT_OFF_MASK   = 8'h10;  // interrupt mask, same layout

  // ==========================================================================
  // control register fields
  // ==========================================================================
  localparam int PMT_CTRL_PRE_LSB  = 0;  // prescale_select, 2 bits
  localparam int PMT_CTRL_PRE_MSB  = 1;
  localparam int PMT_CTRL_ON_BIT   = 2;  // timer_on_bit
  localparam int PMT_CTRL_POST_LSB = 3;  // postscale_select, 4 bits
  localparam int PMT_CTRL_POST_MSB = 6;
  localparam int PMT_FLAG_MATCH    = 0;  // timer_match_flag position in status and mask

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [6:0] PMT_RST_CTRL   = 7'h00;
  localparam logic [7:0] PMT_RST_COUNT  = 8'h00;
  localparam logic [7:0] PMT_RST_PERIOD = 8'hFF;
  localparam logic [0:0] PMT_RST_STATUS = 1'h0;
  localparam logic [0:0] PMT_RST_MASK   = 1'h0;

  // ==========================================================================
  // prescale codes and their terminal counts (ratio minus one)
  // ==========================================================================
  localparam logic [1:0] PMT_PRE_DIV1  = 2'h0;
  localparam logic [1:0] PMT_PRE_DIV4  = 2'h1;
  localparam logic [3:0] PMT_TERM_DIV1  = 4'h0;
  localparam logic [3:0] PMT_TERM_DIV4  = 4'h3;
  localparam logic [3:0] PMT_TERM_DIV16 = 4'hF;

endpackage : pmt_pkg

// *** hw/pmt_scaler.sv ***
// pmt_scaler: 4-bit event divider used as prescaler and as postscaler
`timescale 1ns/1ps
`default_nettype none

module pmt_scaler (
  input  wire logic       core_clk,  // instruction clock
  input  wire logic       nrst,      // async reset, active low
  input  wire logic       clr,       // synchronous clear of the divider count
  input  wire logic       step,      // one input event
  input  wire logic [3:0] term,      // ratio minus one
  output logic            pulse,     // one output event per term+1 steps
  output logic      [3:0] cnt        // current divider count
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  // a step that reaches the terminal count fires and wraps the divider
  assign pulse = step && (cnt_q >= term);
  assign cnt   = cnt_q;

  // next count: clear dominates, so a step in a clearing cycle is dropped
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = 4'h0;
    end else if (pulse) begin
      cnt_d = 4'h0;
    end else if (step) begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  // divider count register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : pmt_scaler

`default_nettype wire

// *** hw/pmt_timer.sv ***
// pmt_timer: 8-bit period match timer with prescaler, postscaler and apb registers
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - the timer counts on the instruction clock only, fed through the prescaler
// - prescaler divides by 1, 4 or 16; each output increments the count
// - count and period compare continuously; count climbs from zero to the period
// - on a match the next increment loads zero instead of count plus one
// - each match steps the postscaler, ratios 1 to 16
// - a postscaler output sets the match flag, held until software clears it
// - software reads and writes count and period at any time
// - every reset loads count with zero and period with all ones
// - timer runs while the on bit is one, stops while zero
// - count write, control write and reset clear prescaler and postscaler
// - a control write leaves the count value untouched
// - postscale field value plus one gives the ratio, 0000 to 1111
module pmt_timer (
  input  wire logic        core_clk,  // instruction clock, 200 MHz
  input  wire logic        nrst,      // async reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction, high for write
  input  wire logic [7:0]  paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  input  wire logic [3:0]  pstrb,     // apb byte strobes, lane 0 used
  output logic             pready,    // apb ready, always one
  output logic      [31:0] prdata,    // apb read data, registered
  output logic             pslverr,   // apb error on unmapped address
  output logic             irq        // level interrupt, unmasked flag set
);

  import pmt_pkg::*;

  // ==========================================================================
  // state
  // ==========================================================================
  logic [6:0]  ctrl_q;     // timer_control_register, bit 7 reads zero
  logic [7:0]  count_q;    // count_register
  logic [7:0]  period_q;   // period_register
  logic [0:0]  status_q;   // peripheral_irq_flags
  logic [0:0]  mask_q;     // interrupt mask
  logic [31:0] rdata_q;    // read data captured in the setup phase

  logic        timer_on;
  logic [1:0]  pre_sel;
  logic [3:0]  post_sel;
  logic [3:0]  pre_term;
  logic        tick;       // prescaler output
  logic        match;      // count equals period on a tick
  logic        post_pulse; // postscaler output
  logic [3:0]  pre_cnt;
  logic [3:0]  post_cnt;
  logic        scaler_clr;

  // ==========================================================================
  // apb decode
  // ==========================================================================
  logic        setup;
  logic        access;
  logic        wr_ok;
  logic        mapped;
  logic        wr_ctrl;
  logic        wr_count;
  logic        wr_period;
  logic        wr_status;
  logic        wr_mask;
  logic        rd_status;

  assign setup  = psel && !penable;
  assign access = psel && penable;
  // only lane 0 carries register bits; a write with lane 0 off changes nothing
  assign wr_ok  = access && pwrite && pstrb[0];

  always_comb begin
    mapped = 1'b0;
    unique case (paddr)
      PMT_OFF_CTRL, PMT_OFF_COUNT, PMT_OFF_PERIOD,
      PMT_OFF_STATUS, PMT_OFF_MASK: mapped = 1'b1;
      default:                      mapped = 1'b0;
    endcase
  end

  assign wr_ctrl   = wr_ok && (paddr == PMT_OFF_CTRL);
  assign wr_count  = wr_ok && (paddr == PMT_OFF_COUNT);
  assign wr_period = wr_ok && (paddr == PMT_OFF_PERIOD);
  assign wr_status = wr_ok && (paddr == PMT_OFF_STATUS);
  assign wr_mask   = wr_ok && (paddr == PMT_OFF_MASK);
  assign rd_status = access && !pwrite && (paddr == PMT_OFF_STATUS);

  // zero wait states: the read word is already latched from the setup phase
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = rdata_q;

  // ==========================================================================
  // control fields
  // ==========================================================================
  assign timer_on = ctrl_q[PMT_CTRL_ON_BIT];
  assign pre_sel  = ctrl_q[PMT_CTRL_PRE_MSB:PMT_CTRL_PRE_LSB];
  assign post_sel = ctrl_q[PMT_CTRL_POST_MSB:PMT_CTRL_POST_LSB];

  // prescale code to terminal count; both 1x codes mean divide by 16
  always_comb begin
    unique case (pre_sel)
      PMT_PRE_DIV1: pre_term = PMT_TERM_DIV1;
      PMT_PRE_DIV4: pre_term = PMT_TERM_DIV4;
      default:      pre_term = PMT_TERM_DIV16;
    endcase
  end

  // software writes to count or control restart both dividers
  assign scaler_clr = wr_count || wr_ctrl;

  // ==========================================================================
  // prescaler and postscaler
  // ==========================================================================
  // the prescaler sees the core clock as its input event while the timer is on
  pmt_scaler u_pre (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (scaler_clr),
    .step     (timer_on && !scaler_clr),
    .term     (pre_term),
    .pulse    (tick),
    .cnt      (pre_cnt)
  );

  // a tick with count at the period is a match event
  assign match = tick && (count_q == period_q);

  // postscaler steps once per match, field value is the terminal count
  pmt_scaler u_post (
    .core_clk (core_clk),
    .nrst     (nrst),
    .clr      (scaler_clr),
    .step     (match),
    .term     (post_sel),
    .pulse    (post_pulse),
    .cnt      (post_cnt)
  );

  // ==========================================================================
  // control register
  // ==========================================================================
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= PMT_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[6:0];
    end
  end

  // ==========================================================================
  // count register
  // ==========================================================================
  // a software write wins over an increment in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= PMT_RST_COUNT;
    end else if (wr_count) begin
      count_q <= pwdata[7:0];
    end else if (match) begin
      count_q <= 8'h00;
    end else if (tick) begin
      count_q <= count_q + 8'h01;
    end
  end

  // ==========================================================================
  // period register
  // ==========================================================================
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      period_q <= PMT_RST_PERIOD;
    end else if (wr_period) begin
      period_q <= pwdata[7:0];
    end
  end

  // ==========================================================================
  // interrupt status and mask
  // ==========================================================================
  // the flag is sticky; a postscaler event in the clearing read cycle survives
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      status_q <= PMT_RST_STATUS;
    end else if (post_pulse) begin
      status_q[PMT_FLAG_MATCH] <= 1'b1;
    end else if (rd_status) begin
      status_q <= PMT_RST_STATUS;
    end
  end

  // writes to status are ignored; only a read clears it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_q <= PMT_RST_MASK;
    end else if (wr_mask) begin
      mask_q <= pwdata[0:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // ==========================================================================
  // read data
  // ==========================================================================
  // captured at the setup edge so prdata comes from a flip-flop
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        PMT_OFF_CTRL:   rdata_q <= {25'h0, ctrl_q};
        PMT_OFF_COUNT:  rdata_q <= {24'h0, count_q};
        PMT_OFF_PERIOD: rdata_q <= {24'h0, period_q};
        PMT_OFF_STATUS: rdata_q <= {31'h0, status_q};
        PMT_OFF_MASK:   rdata_q <= {31'h0, mask_q};
        default:        rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  // helper: cycles the prescaler has run since its last tick or clear
  logic [4:0] gap_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_q <= 5'h00;
    end else if (scaler_clr || tick) begin
      gap_q <= 5'h00;
    end else if (timer_on) begin
      gap_q <= gap_q + 5'h01;
    end
  end

  property p_stop_hold;
    @(posedge core_clk) disable iff (!nrst)
      !timer_on && !wr_count && !wr_ctrl |=> $stable(count_q) && !tick && !$past(match);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("count moved while the timer was stopped");

  property p_wrap;
    @(posedge core_clk) disable iff (!nrst)
      tick && (count_q == period_q) && !wr_count |=> count_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("count did not reload zero after a match");

  property p_inc;
    @(posedge core_clk) disable iff (!nrst)
      tick && (count_q != period_q) && !wr_count |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_inc: assert property (p_inc)
    else $error("count did not advance by one on a tick");

  property p_pre_ratio;
    @(posedge core_clk) disable iff (!nrst)
      tick |-> gap_q == {1'b0, pre_term};
  endproperty
  a_pre_ratio: assert property (p_pre_ratio)
    else $error("prescaler tick spacing does not match the select");

  property p_post_cause;
    @(posedge core_clk) disable iff (!nrst)
      post_pulse |-> match && (post_cnt == post_sel) ##1 status_q[PMT_FLAG_MATCH];
  endproperty
  a_post_cause: assert property (p_post_cause)
    else $error("postscaler output without its match count");

  property p_flag_sticky;
    @(posedge core_clk) disable iff (!nrst)
      status_q[PMT_FLAG_MATCH] && !rd_status |=> status_q[PMT_FLAG_MATCH];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("match flag dropped without a status read");

  property p_ctrl_keeps_count;
    @(posedge core_clk) disable iff (!nrst)
      wr_ctrl && !wr_count |=> $stable(count_q);
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count)
    else $error("control write changed the count");

  property p_clr_scalers;
    @(posedge core_clk) disable iff (!nrst)
      scaler_clr |=> (pre_cnt == 4'h0) && (post_cnt == 4'h0);
  endproperty
  a_clr_scalers: assert property (p_clr_scalers)
    else $error("scaler counts not cleared by a register write");

  property p_count_write;
    @(posedge core_clk) disable iff (!nrst)
      wr_count |=> count_q == $past(pwdata[7:0]);
  endproperty
  a_count_write: assert property (p_count_write)
    else $error("count write did not take effect");

  property p_irq_level;
    @(posedge core_clk) disable iff (!nrst)
      post_pulse && mask_q[PMT_FLAG_MATCH] && !wr_mask |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("unmasked match flag did not raise the interrupt");

  c_wrap: cover property (@(posedge core_clk) disable iff (!nrst) match ##1 tick);
  c_post16: cover property (@(posedge core_clk) disable iff (!nrst)
    post_pulse && (post_sel == 4'hF));
  c_flag_clear: cover property (@(posedge core_clk) disable iff (!nrst)
    status_q[PMT_FLAG_MATCH] && rd_status ##1 !status_q[PMT_FLAG_MATCH]);
  c_pre16: cover property (@(posedge core_clk) disable iff (!nrst)
    tick && (pre_term == PMT_TERM_DIV16));

endmodule : pmt_timer

`default_nettype wire

// *** test/pmt_timer_bench.sv ***
// pmt_timer_bench: self-checking testbench of the period match timer
`timescale 1ns/1ps
`default_nettype none

module pmt_timer_bench;
  import pmt_pkg::*;

  // ==========================================================================
  // signals, counters and the device
  // ==========================================================================
  localparam int LIMIT = 20000;  // cycle ceiling, the run needs about five hundred
  logic        core_clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;

  pmt_timer dut (
    .core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .irq(irq)
  );

  // free-running 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a hung handshake or wait ends here instead of running forever
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures = failures + 1;
      final_report();
    end
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic final_report();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic apply_reset();
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
  endtask : apply_reset

  // one apb transfer; request held until pready is seen high at an access edge
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0);
    check(name, rd, exp);
  endtask : rdchk

  // control word: postscale field, on bit, prescale code
  function automatic logic [31:0] ctl(input logic on, input logic [1:0] pre, input logic [3:0] post);
    return {25'h0, post, on, pre};
  endfunction : ctl

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset_and_regs();
    rdchk("ctrl reset", PMT_OFF_CTRL, 32'h0);
    rdchk("count reset", PMT_OFF_COUNT, 32'h0);
    rdchk("period reset", PMT_OFF_PERIOD, 32'h0000_00FF);
    rdchk("status reset", PMT_OFF_STATUS, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    xfer(1'b1, PMT_OFF_COUNT, 32'h0000_00A5);
    // a write with lane 0 off must leave the count alone
    pstrb <= 4'hE;
    xfer(1'b1, PMT_OFF_COUNT, 32'h0000_0033);
    pstrb <= 4'hF;
    xfer(1'b1, PMT_OFF_PERIOD, 32'hFFFF_FF5A);          // upper bits must be dropped
    repeat (10) @(posedge core_clk);
    rdchk("count rw", PMT_OFF_COUNT, 32'h0000_00A5);
    rdchk("period rw", PMT_OFF_PERIOD, 32'h0000_005A);
  endtask : t_reset_and_regs

  // run 32 edges between the start and stop writes for every prescale code
  task automatic t_prescale();
    int ratio [4] = '{1, 4, 16, 16};
    xfer(1'b1, PMT_OFF_PERIOD, 32'h0000_00FF);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, PMT_OFF_COUNT, 32'h0);
      xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, c[1:0], 4'h0));
      repeat (30) @(posedge core_clk);
      xfer(1'b1, PMT_OFF_CTRL, 32'h0);
      repeat (8) @(posedge core_clk);
      rdchk("prescaled count", PMT_OFF_COUNT, 32'(32 / ratio[c]));
    end
  endtask : t_prescale

  // a mid-run control or count write restarts the divide-by-4 phase
  task automatic t_clear(input logic by_count);
    xfer(1'b1, PMT_OFF_COUNT, 32'h0);
    xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, 2'h1, 4'h0));
    // six steps leave the divider at two, so a missing clear adds one tick
    repeat (4) @(posedge core_clk);
    if (by_count) begin
      xfer(1'b1, PMT_OFF_COUNT, 32'h0000_0005);
    end else begin
      xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, 2'h1, 4'h0));
    end
    repeat (4) @(posedge core_clk);
    xfer(1'b1, PMT_OFF_CTRL, 32'h0);
    rdchk("count after clear", PMT_OFF_COUNT, by_count ? 32'h6 : 32'h2);
  endtask : t_clear

  // period 2, seven ticks: 0 1 2 0 1 2 0 1
  task automatic t_match();
    xfer(1'b1, PMT_OFF_PERIOD, 32'h0000_0002);
    xfer(1'b1, PMT_OFF_COUNT, 32'h0);
    xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, 2'h0, 4'h0));
    repeat (5) @(posedge core_clk);
    xfer(1'b1, PMT_OFF_CTRL, 32'h0);
    rdchk("count wrap", PMT_OFF_COUNT, 32'h1);
    // irq looked at before the status read, while the flag is still set
    check("irq masked", {31'h0, irq}, 32'h0);
    rdchk("flag masked", PMT_OFF_STATUS, 32'h1);
  endtask : t_match

  // period 0 makes every tick a match; irq shows field value plus two negedges after the start
  task automatic t_postscale();
    logic [3:0] post [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
    int d;
    xfer(1'b1, PMT_OFF_PERIOD, 32'h0);
    xfer(1'b1, PMT_OFF_COUNT, 32'h0);  // a count above the period would wrap the long way first
    xfer(1'b1, PMT_OFF_MASK, 32'h1);
    foreach (post[i]) begin
      xfer(1'b1, PMT_OFF_CTRL, 32'h0);
      xfer(1'b0, PMT_OFF_STATUS, 32'h0);
      @(negedge core_clk);
      check("irq idle", {31'h0, irq}, 32'h0);
      xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, 2'h0, post[i]));
      d = 0;
      while (irq !== 1'b1 && d < 64) begin
        @(negedge core_clk);
        d++;
      end
      check("postscale delay", 32'(d), {28'h0, post[i]} + 32'h2);
      xfer(1'b1, PMT_OFF_CTRL, 32'h0);
      @(negedge core_clk);
      check("irq held", {31'h0, irq}, 32'h1);
      rdchk("flag set", PMT_OFF_STATUS, 32'h1);
      @(negedge core_clk);
      check("irq cleared", {31'h0, irq}, 32'h0);
    end
  endtask : t_postscale

  // reset while counting restores every register
  task automatic t_midreset();
    xfer(1'b1, PMT_OFF_CTRL, ctl(1'b1, 2'h0, 4'h0));
    repeat (10) @(posedge core_clk);
    apply_reset();
    rdchk("count after reset", PMT_OFF_COUNT, 32'h0);
    rdchk("period after reset", PMT_OFF_PERIOD, 32'h0000_00FF);
    rdchk("ctrl after reset", PMT_OFF_CTRL, 32'h0);
    rdchk("mask after reset", PMT_OFF_MASK, 32'h0);
    check("irq after reset", {31'h0, irq}, 32'h0);
    rdchk("status after reset", PMT_OFF_STATUS, 32'h0);
  endtask : t_midreset

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pstrb   = 4'hF;
    apply_reset();
    t_reset_and_regs();
    t_prescale();
    t_clear(1'b0);
    t_clear(1'b1);
    t_match();
    t_postscale();
    t_midreset();
    final_report();
  end

endmodule : pmt_timer_bench

`default_nettype wire
